//--- verilog/distortion_alarm_pkg.sv
// Constants, register map and encodings for the current distortion alarm block.
// Assumes a 25 MHz system clock and a 32-bit Avalon-MM register bus.
package distortion_alarm_pkg;

	// ==========================================================
	// Clock and timing
	// ==========================================================
	localparam int CLK_HZ            = 25_000_000;
	localparam int DELAY_STEP_US     = 5000;
	localparam int STEP_CYCLES       = CLK_HZ / 1_000_000 * DELAY_STEP_US;
	localparam int DELAY_STEPS_MAX   = 360000;
	localparam logic [18:0] DELAY_STEPS_DEF = 19'h007d0;
	localparam int MS_CYCLES         = CLK_HZ / 1000;

	// ==========================================================
	// Level encoding: hundredths of a percent
	// ==========================================================
	localparam logic [13:0] LEVEL_MIN = 14'h000a;
	localparam logic [13:0] LEVEL_MAX = 14'h2710;
	localparam logic [13:0] LEVEL_DEF = 14'h03e8;
	localparam int RESET_NUM = 97;
	localparam int RESET_DEN = 100;

	// ==========================================================
	// Register byte offsets
	// ==========================================================
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_LVL_PH   = 8'h04;
	localparam logic [7:0] REG_LVL_R1   = 8'h08;
	localparam logic [7:0] REG_LVL_R2   = 8'h0c;
	localparam logic [7:0] REG_DLY_PH   = 8'h10;
	localparam logic [7:0] REG_DLY_R1   = 8'h14;
	localparam logic [7:0] REG_DLY_R2   = 8'h18;
	localparam logic [7:0] REG_STATUS   = 8'h1c;
	localparam logic [7:0] REG_EVT_LAST = 8'h20;
	localparam logic [7:0] REG_HIST_SEL = 8'h24;
	localparam logic [7:0] REG_HIST_A   = 8'h28;
	localparam logic [7:0] REG_HIST_B   = 8'h2c;

	// CTRL fields.
	localparam int CTRL_DIS_PH   = 0;
	localparam int CTRL_DIS_R1   = 1;
	localparam int CTRL_DIS_R2   = 2;
	localparam int CTRL_POWER    = 3;
	localparam int CTRL_FORCE_EN = 4;
	localparam int CTRL_SW_BLK   = 5;
	localparam int CTRL_EVT_LSB  = 6;
	localparam int CTRL_MODE_LSB = 8;
	localparam int CTRL_SG_LSB   = 11;
	localparam logic [31:0] CTRL_RESET = 32'h000001c0;

	localparam logic [1:0] EVT_SEL_ON   = 2'h1;
	localparam logic [1:0] EVT_SEL_OFF  = 2'h2;

	// Operating behaviour codes.
	localparam logic [2:0] BEH_ON       = 3'h1;
	localparam logic [2:0] BEH_BLOCKED  = 3'h2;
	localparam logic [2:0] BEH_TEST     = 3'h3;
	localparam logic [2:0] BEH_TEST_BLK = 3'h4;
	localparam logic [2:0] BEH_OFF      = 3'h5;

	// Condition codes.
	localparam logic [1:0] COND_NORMAL  = 2'h0;
	localparam logic [1:0] COND_START   = 2'h1;
	localparam logic [1:0] COND_ALARM   = 2'h2;
	localparam logic [1:0] COND_BLOCKED = 2'h3;

	// Event codes: bit 0 is 1 for ON, 0 for OFF.
	localparam logic [3:0] EV_START_PH  = 4'h0;
	localparam logic [3:0] EV_START_R1  = 4'h2;
	localparam logic [3:0] EV_START_R2  = 4'h4;
	localparam logic [3:0] EV_ALARM_PH  = 4'h6;
	localparam logic [3:0] EV_ALARM_R1  = 4'h8;
	localparam logic [3:0] EV_ALARM_R2  = 4'ha;
	localparam logic [3:0] EV_BLOCKED   = 4'hc;

	localparam int HIST_DEPTH = 12;

endpackage : distortion_alarm_pkg

//--- verilog/distortion_alarm.sv
// Current harmonic distortion alarm: pick-up, blocking, definite delay, events and history.
// Assumes distortion values arrive from a front end already as hundredths of a percent.
`timescale 1ns/1ps

// Contract
// - Each channel has its own enable, 0 enabled, 1 disabled; disabled never alarms.
// - Phase pick-up when any of three phases exceeds one shared level.
// - Each residual input has its own level; levels 0.10..100.00 percent, default 10.
// - Pick-up releases only below 97 percent of the level setting.
// - Blocking input is sampled at the start of each processing cycle.
// - Pick-up without blocking raises START and runs the alarm delay.
// - Pick-up under blocking raises BLOCKED instead, with no timer.
// - Blocking during START drops START as if the pick-up released.
// - ALARM rises when START has lasted its own delay, 0..1800 s in 5 ms.
// - Blocking issues a time-stamped event with start values and fault type.
// - Software blocking is accepted only while stage forcing is enabled.
// - Fourteen event kinds: START/ALARM ON/OFF per channel plus BLOCKED ON/OFF.
// - A setting chooses ON, OFF or both events for the event buffer.
// - History of last 12 ON events with time, event, phase values, group.
// - Condition code 0 normal, 1 start, 2 alarm, 3 blocked.
// - Behaviour code 1 on, 2 blocked, 3 test, 4 test blocked, 5 off.
// - One shared setting picks amplitude (0) or power (1) ratio.
module distortion_alarm #(
	parameter int STEP_CYC = distortion_alarm_pkg::STEP_CYCLES,
	parameter int MS_CYC   = distortion_alarm_pkg::MS_CYCLES
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rstn_i,
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        meas_valid_i,
	input  wire logic [13:0] amp_ph1_i,
	input  wire logic [13:0] amp_ph2_i,
	input  wire logic [13:0] amp_ph3_i,
	input  wire logic [13:0] amp_r1_i,
	input  wire logic [13:0] amp_r2_i,
	input  wire logic [13:0] pwr_ph1_i,
	input  wire logic [13:0] pwr_ph2_i,
	input  wire logic [13:0] pwr_ph3_i,
	input  wire logic [13:0] pwr_r1_i,
	input  wire logic [13:0] pwr_r2_i,
	input  wire logic        block_i,
	output logic [2:0]       start_o,
	output logic [2:0]       alarm_o,
	output logic             blocked_o,
	output logic             event_valid_o,
	output logic [3:0]       event_code_o,
	output logic [31:0]      event_time_o,
	output logic [1:0]       condition_o
);
	import distortion_alarm_pkg::*;

	if (STEP_CYC < 1 || MS_CYC < 1) begin : g_bad_cycles
		$error("Cycle counts must be positive.");
	end

	// ==========================================================
	// Pin synchronisers and registers
	// ==========================================================
	logic        blk_s1_ff, blk_s2_ff, val_s1_ff, val_s2_ff, val_d_ff;
	logic [31:0] ctrl_ff;
	logic [13:0] lvl_ff [3];
	logic [18:0] dly_ff [3];
	logic [3:0]  hist_sel_ff;
	logic [31:0] ms_time_ff;
	logic [$clog2(MS_CYC+1)-1:0]   ms_cnt_ff;
	logic [$clog2(STEP_CYC+1)-1:0] step_cnt_ff;
	logic [2:0]  pick_ff, start_ff, alarm_ff;
	logic        blocked_ff, blk_cyc_ff;
	logic [18:0] tmr_ff [3];
	logic [13:0] val_ff [5];
	logic        evt_v_ff;
	logic [3:0]  evt_c_ff, last_evt_ff;
	logic [31:0] evt_t_ff;
	logic [31:0] rd_ff;
	logic        ack_ff;
	logic [31:0] hist_a [HIST_DEPTH];
	logic [63:0] hist_b [HIST_DEPTH];
	logic [3:0]  hist_wp_ff;
	logic [6:0]  pend_ff;

	// ==========================================================
	// Decode and selection
	// ==========================================================
	wire         power_sel  = ctrl_ff[CTRL_POWER];
	wire  [2:0]  mode       = ctrl_ff[CTRL_MODE_LSB +: 3];
	wire  [1:0]  evt_sel    = ctrl_ff[CTRL_EVT_LSB +: 2];
	wire  [2:0]  set_grp    = ctrl_ff[CTRL_SG_LSB +: 3];
	wire  [2:0]  dis        = ctrl_ff[CTRL_DIS_R2:CTRL_DIS_PH];
	wire         sw_blk     = ctrl_ff[CTRL_FORCE_EN] & ctrl_ff[CTRL_SW_BLK];
	wire         mode_blk   = (mode == BEH_BLOCKED) || (mode == BEH_TEST_BLK);
	wire         mode_off   = (mode == BEH_OFF);
	wire         tick       = val_s2_ff & ~val_d_ff;
	wire         step_tick  = (step_cnt_ff == STEP_CYC[$bits(step_cnt_ff)-1:0] - 1'b1);
	// On a tick the fresh blocking sample is used at once, so a new pick-up never flashes START.
	wire         blk_now    = tick ? (blk_s2_ff | sw_blk | mode_blk) : blk_cyc_ff;
	wire  [13:0] cur [5];
	assign cur[0] = power_sel ? pwr_ph1_i : amp_ph1_i;
	assign cur[1] = power_sel ? pwr_ph2_i : amp_ph2_i;
	assign cur[2] = power_sel ? pwr_ph3_i : amp_ph3_i;
	assign cur[3] = power_sel ? pwr_r1_i  : amp_r1_i;
	assign cur[4] = power_sel ? pwr_r2_i  : amp_r2_i;

	// Compare x*100 against level*100 (operate) and level*97 (release).
	logic [2:0] above, below;
	always_comb begin
		logic [21:0] rel;
		rel = '0;
		for (int c = 0; c < 3; c++) begin
			rel = 22'(lvl_ff[c]) * 22'(RESET_NUM);
			if (c == 0) begin
				above[c] = (cur[0] > lvl_ff[0]) | (cur[1] > lvl_ff[0]) | (cur[2] > lvl_ff[0]);
				below[c] = (22'(cur[0]) * 22'(RESET_DEN) < rel) & (22'(cur[1]) * 22'(RESET_DEN) < rel)
				         & (22'(cur[2]) * 22'(RESET_DEN) < rel);
			end else begin
				above[c] = cur[c+2] > lvl_ff[c];
				below[c] = 22'(cur[c+2]) * 22'(RESET_DEN) < rel;
			end
		end
	end

	logic [2:0] nxt_pick, nxt_start, nxt_alarm;
	logic       nxt_blocked;
	always_comb begin
		for (int c = 0; c < 3; c++) begin
			if (dis[c] || mode_off)
				nxt_pick[c] = 1'b0;
			else if (tick)
				nxt_pick[c] = pick_ff[c] ? ~below[c] : above[c];
			else
				nxt_pick[c] = pick_ff[c];
		end
		nxt_start   = nxt_pick & {3{~blk_now}};
		nxt_alarm   = alarm_ff & nxt_start;
		for (int c = 0; c < 3; c++) begin
			if (start_ff[c] && nxt_start[c] && tmr_ff[c] >= dly_ff[c])
				nxt_alarm[c] = 1'b1;
		end
		nxt_blocked = |nxt_pick & blk_now;
	end

	// Changes wait in a pending set and leave one per cycle, lowest index first, so none is lost.
	wire  [6:0] cur_st   = {blocked_ff, alarm_ff, start_ff};
	wire  [6:0] nxt_st   = {nxt_blocked, nxt_alarm, nxt_start};
	wire  [6:0] pend_all = pend_ff | (cur_st ^ nxt_st);
	logic       chg;
	logic [3:0] chg_code;
	logic [6:0] nxt_pend;
	always_comb begin
		chg      = 1'b0;
		chg_code = EV_BLOCKED;
		nxt_pend = pend_all;
		for (int c = 6; c >= 0; c--) begin
			if (pend_all[c]) begin
				chg      = 1'b1;
				chg_code = EV_START_PH + 4'(2 * c) + {3'h0, nxt_st[c]};
				nxt_pend = pend_all & ~(7'h01 << c);
			end
		end
	end
	wire chg_on  = chg_code[0];
	wire log_ok  = chg_on ? evt_sel[0] : evt_sel[1];

	wire [1:0] nxt_cond = blocked_ff ? COND_BLOCKED : (|alarm_ff ? COND_ALARM :
	                      (|start_ff ? COND_START : COND_NORMAL));
	wire [2:0] beh_code = ctrl_ff[CTRL_FORCE_EN] ? (mode_blk ? BEH_TEST_BLK : BEH_TEST) : mode;

	// ==========================================================
	// Avalon-MM slave: two wait cycles, then answer
	// ==========================================================
	wire        req    = (avs_read_i | avs_write_i) & ~ack_ff & avs_waitrequest_o;
	wire        wr_hit = avs_write_i & ~avs_waitrequest_o;
	wire [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
	                       {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	wire [3:0]  hs      = (hist_sel_ff < 4'(HIST_DEPTH)) ? hist_sel_ff : 4'h0;
	logic [31:0] rd_mux;
	always_comb begin
		case (avs_address_i)
			REG_CTRL:     rd_mux = ctrl_ff;
			REG_LVL_PH:   rd_mux = 32'(lvl_ff[0]);
			REG_LVL_R1:   rd_mux = 32'(lvl_ff[1]);
			REG_LVL_R2:   rd_mux = 32'(lvl_ff[2]);
			REG_DLY_PH:   rd_mux = 32'(dly_ff[0]);
			REG_DLY_R1:   rd_mux = 32'(dly_ff[1]);
			REG_DLY_R2:   rd_mux = 32'(dly_ff[2]);
			REG_STATUS:   rd_mux = {19'h0, beh_code, blocked_ff, alarm_ff, start_ff, condition_o, 1'b0};
			REG_EVT_LAST: rd_mux = 32'(last_evt_ff);
			REG_HIST_SEL: rd_mux = 32'(hist_sel_ff);
			REG_HIST_A:   rd_mux = hist_a[hs];
			REG_HIST_B:   rd_mux = hist_b[hs][31:0];
			default:      rd_mux = 32'h0;
		endcase
	end
	wire [31:0] wr_val = (ctrl_ff & ~be_mask) | (avs_writedata_i & be_mask);

	function automatic logic [13:0] clamp_lvl(input logic [31:0] v);
		if (v[13:0] < LEVEL_MIN || v > 32'(LEVEL_MAX)) return LEVEL_DEF;
		return v[13:0];
	endfunction
	function automatic logic [18:0] clamp_dly(input logic [31:0] v);
		if (v > 32'(DELAY_STEPS_MAX)) return 19'(DELAY_STEPS_MAX);
		return v[18:0];
	endfunction

	// ==========================================================
	// Sequential logic
	// ==========================================================
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			{blk_s1_ff, blk_s2_ff, val_s1_ff, val_s2_ff, val_d_ff} <= '0;
			ack_ff <= 1'b0;
			rd_ff  <= '0;
		end else begin
			blk_s1_ff <= block_i;
			blk_s2_ff <= blk_s1_ff;
			val_s1_ff <= meas_valid_i;
			val_s2_ff <= val_s1_ff;
			val_d_ff  <= val_s2_ff;
			ack_ff    <= req;
			rd_ff     <= rd_mux;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			ctrl_ff     <= CTRL_RESET;
			hist_sel_ff <= '0;
			for (int c = 0; c < 3; c++) begin
				lvl_ff[c] <= LEVEL_DEF;
				dly_ff[c] <= DELAY_STEPS_DEF;
			end
		end else if (wr_hit) begin
			case (avs_address_i)
				REG_CTRL:     ctrl_ff     <= wr_val;
				REG_LVL_PH:   lvl_ff[0]   <= clamp_lvl(avs_writedata_i);
				REG_LVL_R1:   lvl_ff[1]   <= clamp_lvl(avs_writedata_i);
				REG_LVL_R2:   lvl_ff[2]   <= clamp_lvl(avs_writedata_i);
				REG_DLY_PH:   dly_ff[0]   <= clamp_dly(avs_writedata_i);
				REG_DLY_R1:   dly_ff[1]   <= clamp_dly(avs_writedata_i);
				REG_DLY_R2:   dly_ff[2]   <= clamp_dly(avs_writedata_i);
				REG_HIST_SEL: hist_sel_ff <= avs_writedata_i[3:0];
				default:      hist_sel_ff <= hist_sel_ff;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			ms_cnt_ff   <= '0;
			ms_time_ff  <= '0;
			step_cnt_ff <= '0;
		end else begin
			ms_cnt_ff   <= (ms_cnt_ff == MS_CYC[$bits(ms_cnt_ff)-1:0] - 1'b1) ? '0 : ms_cnt_ff + 1'b1;
			ms_time_ff  <= ms_time_ff + ((ms_cnt_ff == MS_CYC[$bits(ms_cnt_ff)-1:0] - 1'b1) ? 32'h1 : 32'h0);
			step_cnt_ff <= step_tick ? '0 : step_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			pick_ff <= '0;
			start_ff <= '0;
			alarm_ff <= '0;
			blocked_ff <= 1'b0;
			blk_cyc_ff <= 1'b0;
			condition_o <= COND_NORMAL;
			for (int c = 0; c < 3; c++) tmr_ff[c] <= '0;
			for (int c = 0; c < 5; c++) val_ff[c] <= '0;
		end else begin
			blk_cyc_ff <= blk_now;
			pick_ff    <= nxt_pick;
			start_ff   <= nxt_start;
			alarm_ff   <= nxt_alarm;
			blocked_ff <= nxt_blocked;
			condition_o <= nxt_cond;
			for (int c = 0; c < 5; c++) val_ff[c] <= cur[c];
			for (int c = 0; c < 3; c++) begin
				if (!nxt_start[c]) tmr_ff[c] <= '0;
				else if (step_tick && tmr_ff[c] < dly_ff[c]) tmr_ff[c] <= tmr_ff[c] + 1'b1;
			end
		end
	end

	// Event port and history.
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			evt_v_ff    <= 1'b0;
			evt_c_ff    <= '0;
			evt_t_ff    <= '0;
			last_evt_ff <= '0;
			hist_wp_ff  <= '0;
			pend_ff     <= '0;
		end else begin
			evt_v_ff <= chg & log_ok;
			pend_ff  <= nxt_pend;
			if (chg && log_ok) begin
				evt_c_ff    <= chg_code;
				evt_t_ff    <= ms_time_ff;
			end
			if (chg) last_evt_ff <= chg_code;
			if (chg && chg_on) begin
				hist_a[hist_wp_ff] <= ms_time_ff;
				hist_b[hist_wp_ff] <= {14'h0, set_grp, 1'b0, chg_code, val_ff[2], val_ff[1], val_ff[0]};
				hist_wp_ff <= (hist_wp_ff == 4'(HIST_DEPTH - 1)) ? 4'h0 : hist_wp_ff + 1'b1;
			end
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			start_o <= '0;
			alarm_o <= '0;
			blocked_o <= 1'b0;
			event_valid_o <= 1'b0;
			event_code_o <= '0;
			event_time_o <= '0;
			avs_readdata_o <= '0;
			avs_waitrequest_o <= 1'b1;
		end else begin
			start_o <= start_ff;
			alarm_o <= alarm_ff;
			blocked_o <= blocked_ff;
			event_valid_o <= evt_v_ff;
			event_code_o <= evt_c_ff;
			event_time_o <= evt_t_ff;
			avs_readdata_o <= rd_ff;
			avs_waitrequest_o <= ~ack_ff;
		end
	end

endmodule : distortion_alarm

//--- dv/distortion_alarm_chk.sv
// Port-level assertion checker for the distortion alarm block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module distortion_alarm_chk
	import distortion_alarm_pkg::*;
(
	input wire logic        sys_clk_i,
	input wire logic        rstn_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic        avs_waitrequest_o,
	input wire logic [2:0]  start_o,
	input wire logic [2:0]  alarm_o,
	input wire logic        blocked_o,
	input wire logic        event_valid_o,
	input wire logic [3:0]  event_code_o,
	input wire logic [31:0] event_time_o,
	input wire logic [1:0]  condition_o
);
	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	chk_wait_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low for more than one cycle");
	chk_wait_has_request: assert property ($fell(avs_waitrequest_o) |-> (avs_read_i || avs_write_i))
		else $error("waitrequest dropped without a request");
	chk_ack_bounded: assert property ($rose(avs_read_i || avs_write_i) |-> ##[1:4] !avs_waitrequest_o)
		else $error("bus request not answered in time");
	chk_alarm_after_start: assert property ((alarm_o & ~$past(alarm_o) & ~start_o) == 3'h0)
		else $error("alarm rose without start");
	chk_start_not_blocked: assert property ((start_o & ~$past(start_o)) != 3'h0 |-> ##[0:2] !blocked_o)
		else $error("start rose while blocked");
	chk_cond_alarm: assert property ($rose(|alarm_o) |-> ##[0:2] condition_o == COND_ALARM)
		else $error("condition not alarm after alarm");
	chk_cond_normal: assert property ((start_o == 3'h0 && alarm_o == 3'h0 && !blocked_o)[*3]
		|-> condition_o == COND_NORMAL)
		else $error("condition not normal when idle");
	chk_event_time_held: assert property ($changed(event_time_o) |-> event_valid_o)
		else $error("event time changed without an event");
	chk_start_event: assert property ((event_valid_o && event_code_o == (EV_START_PH | 4'h1))
		|-> ##[0:3] start_o[0])
		else $error("start on event without start");
endmodule : distortion_alarm_chk

bind distortion_alarm distortion_alarm_chk chk_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
	.start_o(start_o), .alarm_o(alarm_o), .blocked_o(blocked_o), .event_valid_o(event_valid_o),
	.event_code_o(event_code_o), .event_time_o(event_time_o), .condition_o(condition_o));

//--- dv/meas_front_end.sv
// Model of the harmonic measurement front end and the blocking matrix output.
// Assumes the bench sets amp_v, pwr_v and blk_v by hierarchical non-blocking writes.
`timescale 1ns/1ps
module meas_front_end #(
	parameter int TICK = 10
) (
	input  wire logic   clk_i,
	output logic        meas_valid_o = 1'b0,
	output logic        block_o = 1'b0,
	output logic [13:0] amp_o [5] = '{default: 14'h0000},
	output logic [13:0] pwr_o [5] = '{default: 14'h0000}
);
	logic [13:0] amp_v [5] = '{default: 14'h0000};
	logic [13:0] pwr_v [5] = '{default: 14'h0000};
	logic        blk_v = 1'b0;
	int          cnt = 0;

	// A fresh set is delivered once per TICK cycles and held until the next one.
	always @(posedge clk_i) begin
		cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
		meas_valid_o <= (cnt < TICK / 2);
		if (cnt == 0) begin
			amp_o <= amp_v;
			pwr_o <= pwr_v;
		end
		// The bench raises blocking many steps before any delay runs out.
		block_o <= blk_v;
	end
endmodule : meas_front_end

//--- dv/current_harmonic_distortion_alarm_tb.sv
// Self-checking bench for the distortion alarm block.
// Assumes meas_front_end as the far side and shortened step counts.
`timescale 1ns/1ps
module current_harmonic_distortion_alarm_tb;
	import distortion_alarm_pkg::*;
	localparam int TICK = 10;
	localparam logic [31:0] CTRL_BASE = 32'h000000c0 | (32'(BEH_ON) << CTRL_MODE_LSB);
	logic        sys_clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, event_time;
	logic        avs_waitrequest, meas_valid, block, blocked, event_valid;
	logic [13:0] amp [5];
	logic [13:0] pwr [5];
	logic [2:0]  start, alarm;
	logic [3:0]  event_code;
	logic [3:0]  last_event = 4'hf;
	logic [1:0]  condition;
	int          errors = 0;
	int          samples_checked = 0;

	always #20 sys_clk_i = ~sys_clk_i;

	meas_front_end #(.TICK(TICK)) fe (.clk_i(sys_clk_i), .meas_valid_o(meas_valid), .block_o(block),
		.amp_o(amp), .pwr_o(pwr));

	distortion_alarm #(.STEP_CYC(10), .MS_CYC(5)) dut (
		.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address), .avs_read_i(avs_read),
		.avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_byteenable_i(4'hf),
		.avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest), .meas_valid_i(meas_valid),
		.amp_ph1_i(amp[0]), .amp_ph2_i(amp[1]), .amp_ph3_i(amp[2]), .amp_r1_i(amp[3]), .amp_r2_i(amp[4]),
		.pwr_ph1_i(pwr[0]), .pwr_ph2_i(pwr[1]), .pwr_ph3_i(pwr[2]), .pwr_r1_i(pwr[3]), .pwr_r2_i(pwr[4]),
		.block_i(block), .start_o(start), .alarm_o(alarm), .blocked_o(blocked), .event_valid_o(event_valid),
		.event_code_o(event_code), .event_time_o(event_time), .condition_o(condition));

	always @(posedge sys_clk_i) if (event_valid === 1'b1) last_event <= event_code;

	// ==========================================================
	// Shared tasks
	// ==========================================================
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		if (n >= 50) errors++;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, exp, q);
	endtask : rd

	task automatic ticks(input int n);
		repeat (n * TICK) @(posedge sys_clk_i);
	endtask : ticks

	// ==========================================================
	// Scenarios
	// ==========================================================
	task automatic t_reset;
		rd("ctrl", REG_CTRL, CTRL_BASE);
		for (int i = 0; i < 3; i++) begin
			rd("level", 8'(REG_LVL_PH + 4 * i), 32'(LEVEL_DEF));
			rd("delay", 8'(REG_DLY_PH + 4 * i), 32'(DELAY_STEPS_DEF));
		end
		rd("status", REG_STATUS, 32'(BEH_ON) << 10);
		rd("unmapped", 8'h30, 32'h0);
	endtask : t_reset

	task automatic t_phase;
		fe.amp_v[1] <= LEVEL_DEF;
		ticks(4);
		chk("start at level", 32'h0, start);
		fe.amp_v[1] <= 14'h03e9;
		ticks(4);
		chk("start ph", 32'h1, start);
		chk("cond start", 32'(COND_START), condition);
		chk("alarm early", 32'h0, alarm);
		chk("start event", 32'(EV_START_PH | 4'h1), last_event);
		rd("history", REG_HIST_B, 32'h00fa4000);
		ticks(10);
		chk("alarm ph", 32'h1, alarm);
		fe.amp_v[1] <= 14'h03cb;
		ticks(4);
		chk("hysteresis hold", 32'h1, start);
		fe.amp_v[1] <= 14'h03c9;
		ticks(4);
		chk("release", 32'h0, start | alarm);
	endtask : t_phase

	task automatic t_resid;
		wr(REG_CTRL, CTRL_BASE | (32'h1 << CTRL_DIS_R2));
		wr(REG_LVL_R1, 32'h000001f4);
		fe.amp_v[3] <= 14'h01f5;
		fe.amp_v[4] <= 14'h07d0;
		ticks(4);
		chk("start r1 only", 32'h2, start);
		ticks(10);
		chk("alarm r1 only", 32'h2, alarm);
		fe.amp_v[3] <= 14'h0000;
		fe.amp_v[4] <= 14'h0000;
		wr(REG_CTRL, CTRL_BASE | (32'h1 << CTRL_POWER));
		fe.pwr_v[2] <= 14'h07d0;
		ticks(4);
		chk("power ratio", 32'h1, start);
		fe.pwr_v[2] <= 14'h0000;
		wr(REG_CTRL, CTRL_BASE);
		ticks(4);
	endtask : t_resid

	task automatic t_block;
		fe.blk_v <= 1'b1;
		ticks(3);
		fe.amp_v[0] <= 14'h07d0;
		ticks(4);
		chk("blocked", 32'h1, blocked);
		chk("no start", 32'h0, start);
		chk("cond blocked", 32'(COND_BLOCKED), condition);
		chk("blocked event", 32'(EV_BLOCKED | 4'h1), last_event);
		fe.amp_v[0] <= 14'h0000;
		fe.blk_v <= 1'b0;
		ticks(4);
		fe.amp_v[0] <= 14'h07d0;
		ticks(4);
		chk("start free", 32'h1, start);
		fe.blk_v <= 1'b1;
		ticks(4);
		chk("start dropped", 32'h0, start);
		ticks(45);
		chk("no alarm blocked", 32'h0, alarm);
		fe.amp_v[0] <= 14'h0000;
		fe.blk_v <= 1'b0;
		ticks(4);
	endtask : t_block

	task automatic t_release;
		fe.amp_v[0] <= 14'h07d0;
		ticks(30);
		chk("alarm before delay", 32'h0, alarm);
		fe.amp_v[0] <= 14'h0000;
		ticks(3);
		chk("start cleared", 32'h0, start);
		fe.amp_v[0] <= 14'h07d0;
		ticks(25);
		chk("timer restarted", 32'h0, alarm);
		ticks(22);
		chk("alarm after delay", 32'h1, alarm);
		fe.amp_v[0] <= 14'h0000;
		ticks(4);
	endtask : t_release

	task automatic t_swblk;
		logic [31:0] q;
		wr(REG_CTRL, CTRL_BASE | (32'h1 << CTRL_SW_BLK));
		fe.amp_v[0] <= 14'h07d0;
		ticks(4);
		chk("sw block ignored", 32'h1, start);
		fe.amp_v[0] <= 14'h0000;
		wr(REG_CTRL, CTRL_BASE | (32'h3 << CTRL_FORCE_EN));
		ticks(4);
		fe.amp_v[0] <= 14'h07d0;
		ticks(4);
		chk("sw block", 32'h1, blocked);
		fe.amp_v[0] <= 14'h0000;
		ticks(4);
		for (int m = 1; m <= 5; m++) begin
			wr(REG_CTRL, 32'h000000c0 | (32'(m) << CTRL_MODE_LSB));
			bus(1'b0, REG_STATUS, 32'h0, q);
			chk("behaviour", 32'(m), (q >> 10) & 32'h7);
		end
		wr(REG_CTRL, CTRL_BASE);
	endtask : t_swblk

	task automatic t_events;
		wr(REG_CTRL, CTRL_BASE & ~(32'(EVT_SEL_OFF) << CTRL_EVT_LSB));
		fe.amp_v[3] <= 14'h07d0;
		ticks(4);
		fe.amp_v[3] <= 14'h0000;
		ticks(4);
		chk("on only", 32'(EV_START_R1 | 4'h1), last_event);
		rd("last event", REG_EVT_LAST, 32'(EV_START_R1));
		wr(REG_CTRL, CTRL_BASE & ~(32'(EVT_SEL_ON) << CTRL_EVT_LSB));
		fe.amp_v[0] <= 14'h07d0;
		ticks(4);
		chk("on dropped", 32'(EV_START_R1 | 4'h1), last_event);
		fe.amp_v[0] <= 14'h0000;
		ticks(4);
		chk("off only", 32'(EV_START_PH), last_event);
		wr(REG_CTRL, CTRL_BASE);
	endtask : t_events

	task automatic print_verdict;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (10000) @(posedge sys_clk_i);
		errors++;
		print_verdict();
	end

	initial begin
		repeat (4) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		t_reset();
		wr(REG_DLY_PH, 32'h00000008);
		wr(REG_DLY_R1, 32'h00000008);
		t_phase();
		t_resid();
		wr(REG_DLY_PH, 32'h00000028);
		t_block();
		t_release();
		t_swblk();
		t_events();
		print_verdict();
	end
endmodule : current_harmonic_distortion_alarm_tb
